//--- inc/var_store_pkg.sv
// Shared constants, types and address map of the channel variable store
package var_store_pkg;

  localparam int          DATA_W    = 16;
  localparam int          ADDR_W    = 9;
  localparam int          NUM_AIN   = 16;
  localparam int          CH_VARS   = 16;
  localparam int          NUM_VARS  = (NUM_AIN + 1) * CH_VARS;
  localparam logic [8:0]  LAST_ADDR = 9'h10F;
  localparam logic [4:0]  SVC_CH    = 5'h00;

  // Service channel locations
  localparam logic [8:0]  PERMIT_ADDR = 9'h00D;
  localparam logic [3:0]  TOP_IDX     = 4'h0;
  localparam logic [15:0] TOP_VALUE   = 16'h010F;

  // Analog channel locations
  localparam logic [3:0]  MEAS_IDX = 4'h0;
  localparam logic [3:0]  SIM_IDX  = 4'h1;
  localparam int          SIM_BIT  = 0;

  // Integration period
  localparam int unsigned CLK_KHZ         = 100000;
  localparam int unsigned INTEG_PERIOD_MS = 100;
  localparam int unsigned INTEG_CYC       = CLK_KHZ * INTEG_PERIOD_MS;

  typedef enum logic [2:0] {
    MK_NONE,
    MK_ROM,
    MK_RAM_RO,
    MK_NV_PROT,
    MK_RAM_RW,
    MK_NV_BACKED
  } mem_kind_e;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_IDLE,
    ST_CSUM
  } seq_state_e;

  localparam mem_kind_e SVC_KIND [CH_VARS] = '{
    MK_ROM, MK_ROM, MK_NONE, MK_RAM_RW,
    MK_NONE, MK_NONE, MK_NONE, MK_RAM_RO,
    MK_RAM_RW, MK_NV_PROT, MK_NV_PROT, MK_NONE,
    MK_NONE, MK_RAM_RW, MK_ROM, MK_RAM_RW};

  localparam mem_kind_e AIN_KIND [CH_VARS] = '{
    MK_RAM_RO, MK_NV_BACKED, MK_NV_PROT, MK_NV_PROT,
    MK_RAM_RO, MK_RAM_RW, MK_NONE, MK_NONE,
    MK_NONE, MK_NONE, MK_NONE, MK_NONE,
    MK_NONE, MK_NONE, MK_ROM, MK_RAM_RW};

  function automatic mem_kind_e kind_of(input logic [8:0] a);
    mem_kind_e k;
    k = MK_NONE;
    if (a <= LAST_ADDR)
      k = (a[8:4] == SVC_CH) ? SVC_KIND[a[3:0]] : AIN_KIND[a[3:0]];
    return k;
  endfunction

endpackage

//--- inc/meas_if.sv
// Measurement results from the integrator to the variable store
`timescale 1ns/1ps
interface meas_if;
  logic                               valid;
  logic [4:0]                         ch;
  logic [var_store_pkg::DATA_W-1:0]   value;

  modport src (output valid, output ch, output value);
  modport dst (input valid, input ch, input value);
endinterface

//--- hw/meas_integrator.sv
// Per-channel integration of converter samples over a fixed period
`timescale 1ns/1ps
module meas_integrator #(
  parameter int unsigned PERIOD_CYC = var_store_pkg::INTEG_CYC,
  parameter int          ACC_W      = 40,
  parameter int          SHIFT      = 0
) (
  // Clock and synchronised reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // Converter samples, channel 0..15 means input 1..16
  input  wire logic                             i_smp_valid,
  input  wire logic [3:0]                       i_smp_ch,
  input  wire logic [var_store_pkg::DATA_W-1:0] i_smp_data,
  // Results
  meas_if.src                                   meas
);

  localparam int N = var_store_pkg::NUM_AIN;

  logic [31:0]      tick_cnt_ff;
  logic [ACC_W-1:0] hold_ff [N];
  logic             dumping_ff;
  logic [3:0]       dump_idx_ff;
  logic             valid_ff;
  logic [4:0]       ch_ff;
  logic [var_store_pkg::DATA_W-1:0] value_ff;

  wire tick = tick_cnt_ff == 32'(PERIOD_CYC - 1);

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      tick_cnt_ff <= 32'h00000000;
    else
      tick_cnt_ff <= tick ? 32'h00000000 : tick_cnt_ff + 32'h00000001;

  for (genvar g = 0; g < N; g++)
  begin : g_acc
    logic [ACC_W-1:0] acc_ff;
    wire              hit = i_smp_valid && i_smp_ch == 4'(g);
    wire [ACC_W-1:0]  add = hit ? ACC_W'(i_smp_data) : '0;
    // A sample in the closing cycle still counts for this period
    always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
        acc_ff     <= '0;
        hold_ff[g] <= '0;
      end
      else if (tick)
      begin
        hold_ff[g] <= acc_ff + add;
        acc_ff     <= '0;
      end
      else
        acc_ff <= acc_ff + add;
  end

  // Results leave one per cycle; period must be at least N cycles
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      dumping_ff  <= 1'b0;
      dump_idx_ff <= 4'h0;
      valid_ff    <= 1'b0;
      ch_ff       <= 5'h00;
      value_ff    <= '0;
    end
    else
    begin
      valid_ff <= dumping_ff;
      ch_ff    <= {1'b0, dump_idx_ff} + 5'h01;
      value_ff <= hold_ff[dump_idx_ff][SHIFT +: var_store_pkg::DATA_W];
      if (tick)
        dumping_ff <= 1'b1;
      else if (dump_idx_ff == 4'hF)
        dumping_ff <= 1'b0;
      if (dumping_ff)
        dump_idx_ff <= dump_idx_ff + 4'h1;
    end

  assign meas.valid = valid_ff;
  assign meas.ch    = ch_ff;
  assign meas.value = value_ff;

endmodule // meas_integrator

//--- hw/channel_variable_store.sv
// Channel variable store with volatile, nonvolatile and ROM backing
`timescale 1ns/1ps
// Operation
// - Sixteen variables per channel, channels 0..16
// - Address is channel times 16 plus index
// - Mask ROM variables never change
// - Read-only RAM variables refuse master writes
// - Protected nonvolatile locked after reset
// - Permit raised lets writes reach nonvolatile
// - Nonvolatile contents survive power loss
// - Read-write RAM takes writes at once
// - Read-write RAM cleared on reset, power fail; write permit on reset only
// - Backed RAM reloaded from nonvolatile after reset
// - Backed RAM volatile copy always written
// - Permit raised also writes nonvolatile copy
// - Simulation stops measuring, accepts written value
// - Measurement integrated over fixed period
// - Every reset clears write permit
// - Permit falling starts nonvolatile checksum
module channel_variable_store #(
  parameter int unsigned INTEG_CYC = var_store_pkg::INTEG_CYC,
  parameter logic [15:0] ROM_ID    = 16'h5A5A, // Arbitrary identity
  parameter int          ACC_W     = 40,
  parameter int          SHIFT     = 0
) (
  // Clock and reset
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst_b,
  // Fieldbus master requests
  input  wire logic                             i_req,
  input  wire logic                             i_we,
  input  wire logic [var_store_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [var_store_pkg::DATA_W-1:0] i_wdata,
  output logic                                  o_ack,
  output logic                                  o_err,
  output logic [var_store_pkg::DATA_W-1:0]      o_rdata,
  output logic                                  o_busy,
  // Converter samples
  input  wire logic                             i_smp_valid,
  input  wire logic [3:0]                       i_smp_ch,
  input  wire logic [var_store_pkg::DATA_W-1:0] i_smp_data,
  // Supply monitor pin
  input  wire logic                             i_power_fail,
  // Status
  output logic                                  o_nv_write_permit,
  output logic                                  o_csum_busy,
  output logic [var_store_pkg::DATA_W-1:0]      o_nv_checksum,
  output logic [var_store_pkg::NUM_AIN-1:0]     o_sim_active
);

  localparam int DW = var_store_pkg::DATA_W;
  localparam int NV = var_store_pkg::NUM_VARS;

  // Reset release
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end

  // Power fail pin synchroniser
  logic pf_meta_ff;
  logic pf_sync_ff;
  logic pf_prev_ff;

  always_ff @(posedge i_clk_sys or negedge rst_n_ff)
    if (!rst_n_ff)
    begin
      pf_meta_ff <= 1'b0;
      pf_sync_ff <= 1'b0;
      pf_prev_ff <= 1'b0;
    end
    else
    begin
      pf_meta_ff <= i_power_fail;
      pf_sync_ff <= pf_meta_ff;
      pf_prev_ff <= pf_sync_ff;
    end

  wire pf_rise = pf_sync_ff && !pf_prev_ff;

  // Storage; nv_mem has no reset so it keeps its contents
  logic [DW-1:0] vol_mem [NV];
  logic [DW-1:0] nv_mem  [NV];

  // Control state
  var_store_pkg::seq_state_e state_ff;
  logic [8:0]                seq_ff;
  logic [DW-1:0]             csum_acc_ff;
  logic                      permit_ff;
  logic [15:0]               sim_ff;
  logic                      busy_ff;
  logic                      ack_ff;
  logic                      err_ff;
  logic [DW-1:0]             rdata_ff;
  logic [DW-1:0]             csum_ff;
  logic                      csum_busy_ff;

  // Measurement results
  meas_if meas_bus ();

  meas_integrator #(
    .PERIOD_CYC (INTEG_CYC),
    .ACC_W      (ACC_W),
    .SHIFT      (SHIFT)
  ) u_integ (
    .i_clk      (i_clk_sys),
    .i_rst_n    (rst_n_ff),
    .i_smp_valid(i_smp_valid),
    .i_smp_ch   (i_smp_ch),
    .i_smp_data (i_smp_data),
    .meas       (meas_bus)
  );

  // Request decode
  wire       take    = i_req && !busy_ff;
  wire [4:0] a_ch    = i_addr[8:4];
  wire [3:0] a_idx   = i_addr[3:0];
  wire       a_svc   = a_ch == var_store_pkg::SVC_CH;
  wire [3:0] a_ain   = 4'(a_ch - 5'h01);
  var_store_pkg::mem_kind_e base_kind;
  var_store_pkg::mem_kind_e acc_kind;
  assign base_kind = var_store_pkg::kind_of(i_addr);

  wire is_meas = !a_svc && a_idx == var_store_pkg::MEAS_IDX;
  wire sim_hit = is_meas && sim_ff[a_ain];
  // Simulated channel makes its measurement writable
  assign acc_kind = (base_kind == var_store_pkg::MK_RAM_RO && sim_hit)
                    ? var_store_pkg::MK_RAM_RW : base_kind;

  wire kind_vol = acc_kind == var_store_pkg::MK_RAM_RW ||
                  acc_kind == var_store_pkg::MK_NV_BACKED;
  wire kind_nv  = acc_kind == var_store_pkg::MK_NV_PROT ||
                  acc_kind == var_store_pkg::MK_NV_BACKED;

  wire wr_vol    = take && i_we && kind_vol;
  wire wr_nv     = take && i_we && permit_ff && kind_nv;
  wire wr_drop   = take && i_we && !wr_vol && !wr_nv;
  wire wr_permit = wr_vol && i_addr == var_store_pkg::PERMIT_ADDR;
  wire wr_sim    = wr_vol && !a_svc && a_idx == var_store_pkg::SIM_IDX;
  wire permit_fall = wr_permit && permit_ff && !i_wdata[0];

  // Read selection
  wire [DW-1:0] rom_data =
    (a_svc && a_idx == var_store_pkg::TOP_IDX)
    ? var_store_pkg::TOP_VALUE : ROM_ID;
  wire [DW-1:0] rd_data =
    (acc_kind == var_store_pkg::MK_NONE)    ? '0 :
    (acc_kind == var_store_pkg::MK_ROM)     ? rom_data :
    (acc_kind == var_store_pkg::MK_NV_PROT) ? nv_mem[i_addr] :
    (i_addr == var_store_pkg::PERMIT_ADDR)  ? DW'(permit_ff) :
    vol_mem[i_addr];

  // Sequencer decode, shared by the reload and checksum walks
  var_store_pkg::mem_kind_e seq_kind;
  assign seq_kind = var_store_pkg::kind_of(seq_ff);
  wire [DW-1:0] seq_nv   = nv_mem[seq_ff];
  wire          seq_last = seq_ff == var_store_pkg::LAST_ADDR;
  wire          seq_in_nv = seq_kind == var_store_pkg::MK_NV_PROT ||
                            seq_kind == var_store_pkg::MK_NV_BACKED;
  wire [DW-1:0] init_val =
    (seq_kind == var_store_pkg::MK_NV_BACKED) ? seq_nv : '0;
  wire          seq_sim  = seq_ff[8:4] != var_store_pkg::SVC_CH &&
                           seq_ff[3:0] == var_store_pkg::SIM_IDX;
  wire [3:0]    seq_ain  = 4'(seq_ff[8:4] - 5'h01);
  wire          in_init  = state_ff == var_store_pkg::ST_INIT;

  // Measurement write, skipped while simulating
  wire [3:0] m_ain   = 4'(meas_bus.ch - 5'h01);
  wire       m_write = meas_bus.valid && !in_init && !sim_ff[m_ain];
  wire [8:0] m_addr  = {meas_bus.ch, var_store_pkg::MEAS_IDX};

  // Volatile storage writes
  always_ff @(posedge i_clk_sys)
  begin
    if (in_init)
      vol_mem[seq_ff] <= init_val;
    if (m_write)
      vol_mem[m_addr] <= meas_bus.value;
    if (wr_vol)
      vol_mem[i_addr] <= i_wdata;
  end

  // Nonvolatile storage writes
  always_ff @(posedge i_clk_sys)
    if (wr_nv)
      nv_mem[i_addr] <= i_wdata;

  // Simulation flags follow the channel configuration word
  always_ff @(posedge i_clk_sys or negedge rst_n_ff)
    if (!rst_n_ff)
      sim_ff <= 16'h0000;
    else if (in_init && seq_sim)
      sim_ff[seq_ain] <= seq_nv[var_store_pkg::SIM_BIT];
    else if (wr_sim)
      sim_ff[a_ain] <= i_wdata[var_store_pkg::SIM_BIT];

  // Write permit, false from every reset
  always_ff @(posedge i_clk_sys or negedge rst_n_ff)
    if (!rst_n_ff)
      permit_ff <= 1'b0;
    else if (wr_permit)
      permit_ff <= i_wdata[0];

  // Sequencer: reload after reset or power fail, checksum on lock
  always_ff @(posedge i_clk_sys or negedge rst_n_ff)
    if (!rst_n_ff)
    begin
      state_ff     <= var_store_pkg::ST_INIT;
      seq_ff       <= 9'h000;
      busy_ff      <= 1'b1;
      csum_acc_ff  <= '0;
      csum_ff      <= '0;
      csum_busy_ff <= 1'b0;
    end
    else if (pf_rise)
    begin
      state_ff     <= var_store_pkg::ST_INIT;
      seq_ff       <= 9'h000;
      busy_ff      <= 1'b1;
      csum_busy_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        var_store_pkg::ST_INIT:
        begin
          seq_ff <= seq_ff + 9'h001;
          if (seq_last)
          begin
            state_ff <= var_store_pkg::ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        var_store_pkg::ST_IDLE:
        begin
          if (permit_fall)
          begin
            state_ff     <= var_store_pkg::ST_CSUM;
            seq_ff       <= 9'h000;
            csum_acc_ff  <= '0;
            busy_ff      <= 1'b1;
            csum_busy_ff <= 1'b1;
          end
        end
        var_store_pkg::ST_CSUM:
        begin
          seq_ff      <= seq_ff + 9'h001;
          csum_acc_ff <= csum_acc_ff + (seq_in_nv ? seq_nv : '0);
          if (seq_last)
          begin
            csum_ff      <= csum_acc_ff + (seq_in_nv ? seq_nv : '0);
            state_ff     <= var_store_pkg::ST_IDLE;
            busy_ff      <= 1'b0;
            csum_busy_ff <= 1'b0;
          end
        end
      endcase
    end

  // Answers to the master, one cycle after the request
  always_ff @(posedge i_clk_sys or negedge rst_n_ff)
    if (!rst_n_ff)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      ack_ff   <= take;
      err_ff   <= wr_drop ||
                  (take && !i_we &&
                   acc_kind == var_store_pkg::MK_NONE);
      rdata_ff <= (take && !i_we) ? rd_data : '0;
    end

  assign o_ack             = ack_ff;
  assign o_err             = err_ff;
  assign o_rdata           = rdata_ff;
  assign o_busy            = busy_ff;
  assign o_nv_write_permit = permit_ff;
  assign o_csum_busy       = csum_busy_ff;
  assign o_nv_checksum     = csum_ff;
  assign o_sim_active      = sim_ff;

endmodule // channel_variable_store

//--- verif/store_sva.sv
// Port assertions for the channel variable store
`timescale 1ns/1ps
module store_sva (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  // Master requests
  input wire logic        i_req,
  input wire logic        i_we,
  input wire logic [8:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        o_ack,
  input wire logic        o_err,
  input wire logic        o_busy,
  // Status
  input wire logic        o_nv_write_permit,
  input wire logic        o_csum_busy
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  wire logic take = i_req && !o_busy;
  wire logic wr   = take && i_we;
  wire logic pm   = o_nv_write_permit;

  ack_on_take_a: assert property (take |=> o_ack)
    else $error("request not answered");
  ack_has_cause_a: assert property (o_ack |-> $past(take))
    else $error("answer without request");
  rom_locked_a: assert property (wr && i_addr == 9'h00E |=> o_err)
    else $error("mask ROM write accepted");
  ro_refused_a: assert property (wr && i_addr == 9'h007 |=> o_err)
    else $error("read-only write accepted");
  nv_locked_a: assert property (
    wr && i_addr == 9'h009 && !pm |=> o_err)
    else $error("locked nonvolatile write accepted");
  nv_open_a: assert property (
    wr && i_addr == 9'h009 && pm |=> o_ack && !o_err)
    else $error("permitted nonvolatile write refused");
  rw_instant_a: assert property (
    wr && i_addr == 9'h008 |=> o_ack && !o_err)
    else $error("read-write variable refused");
  permit_reset_a: assert property (
    $rose(i_rst_b) |-> (!pm && o_busy) [*8])
    else $error("permit set after reset");
  csum_start_a: assert property (
    wr && i_addr == 9'h00D && !i_wdata[0] && pm |=> o_csum_busy && o_busy)
    else $error("checksum not started");
  csum_len_a: assert property (
    $rose(o_csum_busy) |-> ##[268:276] $fell(o_csum_busy))
    else $error("checksum walk length wrong");

  cover property (wr && i_addr == 9'h00D && i_wdata[0]);
  cover property ($fell(o_csum_busy));
  cover property (o_ack && o_err);
endmodule // store_sva

bind channel_variable_store store_sva u_sva (.i_clk_sys, .i_rst_b, .i_req,
  .i_we, .i_addr, .i_wdata, .o_ack, .o_err, .o_busy, .o_nv_write_permit,
  .o_csum_busy);

//--- verif/bus_master_model.sv
// Fieldbus master model issuing single-word requests
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input  wire logic        i_clk,
  // Request side
  input  wire logic        i_busy,
  output logic             o_req,
  output logic             o_we,
  output logic [8:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial
  begin
    o_req = 1'h0;
    o_we = 1'h0;
    o_addr = 9'h000;
    o_wdata = 16'h0000;
  end

  // Idle gap lets the master request promptly or slowly; at least one
  // idle cycle so the strobe is never lowered and raised in one step
  task automatic xfer(input logic we, input logic [4:0] ch,
    input logic [3:0] idx, input logic [15:0] d, input int gap);
    repeat (gap + 1) @(negedge i_clk);
    for (int n = 0; n < 900 && i_busy !== 1'h0; n++)
      @(negedge i_clk);
    o_we = we;
    o_addr = {ch, idx};
    o_wdata = d;
    o_req = 1'h1;
    @(negedge i_clk);
    o_req = 1'h0;
    // Released lines must not hold stale values
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
endmodule // bus_master_model

//--- verif/test_channel_variable_store.sv
// Self-checking bench for the channel variable store
`timescale 1ns/1ps
module test_channel_variable_store;
  localparam int          PER = 40;
  localparam logic [15:0] ID  = 16'h3C3C; // Arbitrary identity
  logic        clk;
  logic        rst_b;
  logic        req;
  logic        we;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic        err;
  logic [15:0] rdata;
  logic        busy;
  logic        pfail;
  logic        permit;
  logic [15:0] smp_d;
  logic [15:0] sim;
  logic [15:0] csum;
  logic [25:0] note;
  logic [25:0] exp_q[$];
  logic [15:0] n1, n2, b1, b2, r1, v;
  logic [8:0]  rom_a[3] = '{9'h000, 9'h00E, 9'h01E};
  logic [15:0] rom_v[3] = '{16'h010F, ID, ID};
  int          err_count;
  int          cmp_count;

  channel_variable_store #(.INTEG_CYC(PER), .ROM_ID(ID)) dut (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_req(req), .i_we(we),
    .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_err(err),
    .o_rdata(rdata), .o_busy(busy), .i_smp_valid(1'h1),
    .i_smp_ch(4'h0), .i_smp_data(smp_d), .i_power_fail(pfail),
    .o_nv_write_permit(permit), .o_csum_busy(), .o_nv_checksum(csum),
    .o_sim_active(sim));

  bus_master_model mst (.i_clk(clk), .i_busy(busy), .o_req(req),
    .o_we(we), .o_addr(addr), .o_wdata(wdata));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [16:0] seen,
    input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Note the expected answer, then let the master send the request
  task automatic acc(input logic w, input logic [8:0] a,
    input logic [15:0] d, input logic e, input logic [15:0] r);
    exp_q.push_back({a, e, r});
    mst.xfer(w, a[8:4], a[3:0], d, $urandom_range(2));
  endtask

  task automatic done(input string s);
    repeat (3) @(negedge clk);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    chk("pending answers", 17'(exp_q.size()), 17'h00000);
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge clk)
    if (ack === 1'h1)
    begin
      note = exp_q.pop_front();
      chk($sformatf("answer %h", note[25:17]), {err, rdata},
        note[16:0]);
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    rst_b = 1'h0;
    pfail = 1'h0;
    void'($urandom(32'h8DA4D1AC));
    smp_d = 16'($urandom_range(1, 1000));
    n1 = 16'($urandom);
    n2 = 16'($urandom);
    b1 = 16'($urandom);
    b2 = 16'($urandom);
    r1 = 16'($urandom);
    v = 16'($urandom);
    repeat (8) @(negedge clk);
    rst_b = 1'h1;
    acc(1'h0, 9'h003, 16'h0, 1'h0, 16'h0);
    acc(1'h0, 9'h015, 16'h0, 1'h0, 16'h0);
    acc(1'h0, 9'h00D, 16'h0, 1'h0, 16'h0);
    acc(1'h0, 9'h002, 16'h0, 1'h1, 16'h0);
    acc(1'h0, 9'h110, 16'h0, 1'h1, 16'h0);
    done("after reset");
    foreach (rom_a[i])
    begin
      acc(1'h1, rom_a[i], 16'($urandom), 1'h1, 16'h0);
      acc(1'h0, rom_a[i], 16'h0, 1'h0, rom_v[i]);
    end
    acc(1'h1, 9'h007, n1, 1'h1, 16'h0);
    acc(1'h1, 9'h014, n1, 1'h1, 16'h0);
    acc(1'h1, 9'h009, n1, 1'h1, 16'h0);
    done("refusals");
    acc(1'h1, 9'h00D, 16'h1, 1'h0, 16'h0);
    @(negedge clk);
    chk("permit", {16'h0, permit}, 17'h00001);
    // Nonvolatile words start unknown; give every one a known value
    for (int c = 1; c <= 16; c++)
      for (int k = 1; k <= 3; k++)
        acc(1'h1, {5'(c), 4'(k)}, 16'h0000, 1'h0, 16'h0000);
    acc(1'h1, 9'h00A, 16'h0000, 1'h0, 16'h0000);
    acc(1'h1, 9'h009, n1, 1'h0, 16'h0);
    acc(1'h1, 9'h022, n2, 1'h0, 16'h0);
    acc(1'h1, 9'h011, 16'h0, 1'h0, 16'h0);
    acc(1'h1, 9'h021, b1, 1'h0, 16'h0);
    acc(1'h0, 9'h009, 16'h0, 1'h0, n1);
    acc(1'h1, 9'h008, r1, 1'h0, 16'h0);
    acc(1'h0, 9'h008, 16'h0, 1'h0, r1);
    acc(1'h1, 9'h00D, 16'h0, 1'h0, 16'h0);
    acc(1'h1, 9'h021, b2, 1'h0, 16'h0);
    acc(1'h0, 9'h021, 16'h0, 1'h0, b2);
    chk("checksum", {1'h0, csum}, {1'h0, 16'(n1 + n2 + b1)});
    acc(1'h1, 9'h009, b2, 1'h1, 16'h0);
    done("permit");
    rst_b = 1'h0;
    repeat (3) @(negedge clk);
    rst_b = 1'h1;
    acc(1'h0, 9'h021, 16'h0, 1'h0, b1);
    acc(1'h0, 9'h009, 16'h0, 1'h0, n1);
    acc(1'h0, 9'h022, 16'h0, 1'h0, n2);
    acc(1'h0, 9'h008, 16'h0, 1'h0, 16'h0);
    acc(1'h0, 9'h00D, 16'h0, 1'h0, 16'h0);
    done("second reset");
    repeat (3 * PER) @(negedge clk);
    acc(1'h0, 9'h010, 16'h0, 1'h0, 16'(PER * smp_d));
    acc(1'h1, 9'h011, 16'h1, 1'h0, 16'h0);
    repeat (2) @(negedge clk);
    acc(1'h1, 9'h010, v, 1'h0, 16'h0);
    repeat (3 * PER) @(negedge clk);
    acc(1'h0, 9'h010, 16'h0, 1'h0, v);
    chk("simulation", {1'h0, sim}, {15'h0000, b1[0], 1'h1});
    acc(1'h1, 9'h008, r1, 1'h0, 16'h0);
    done("measurement");
    pfail = 1'h1;
    repeat (3) @(negedge clk);
    pfail = 1'h0;
    repeat (4) @(negedge clk);
    acc(1'h0, 9'h008, 16'h0, 1'h0, 16'h0);
    acc(1'h0, 9'h009, 16'h0, 1'h0, n1);
    acc(1'h0, 9'h011, 16'h0, 1'h0, 16'h0);
    repeat (3 * PER) @(negedge clk);
    acc(1'h0, 9'h010, 16'h0, 1'h0, 16'(PER * smp_d));
    done("power fail");
    tally_and_finish();
  end
endmodule // test_channel_variable_store
